// file: rtl/lpc_codec.sv
// Purpose: line pulse encoder and decoder with transmit enable
// Assumes: 20 MHz clock, synchronous active low reset
// Notes:   bits to send pass through a 16 entry buffer
`timescale 1ns/1ps
`default_nettype none
module lpc_codec
  import lpc_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // configuration levels
  input  wire logic i_backplane_mode,
  input  wire logic i_pulse_driver_push_pull_select,
  input  wire logic i_rate_is_2p5,
  // transmit bit stream
  input  wire logic i_tx_valid,
  input  wire logic i_tx_bit,
  output logic      o_tx_ready,
  // received bit stream
  output logic      o_rx_valid,
  output logic      o_rx_bit,
  output logic      o_rx_active,
  // status
  output logic      o_rate_fault,
  output logic      o_tx_busy,
  // pulse pin a
  output logic      o_line_pulse_a_n,
  output logic      o_line_pulse_a_oe,
  // pulse pin b, also the polarity strap
  input  wire logic i_line_pulse_b_n,
  output logic      o_line_pulse_b_n,
  output logic      o_line_pulse_b_oe,
  // receive line
  input  wire logic i_line_receive_in,
  // external driver enable
  output logic      o_transmit_drive_enable_n
);
  // sequencer and timing
  lpc_tx_state_t    state_reg;    // transmit sequencer state
  lpc_tx_state_t    state_next;   // its next value
  logic [CNT_W-1:0] cnt_reg;      // free running cell phase
  logic             bit_reg;      // bit in the current cell
  // captured configuration
  logic             bp_reg;       // backplane mode
  logic             pp_reg;       // push-pull driver
  logic             strap_gnd_reg; // strap pin seen low
  logic             run_reg;      // out of reset
  // registered pin activity
  logic             pa_act_reg;   // pulse a active
  logic             pb_act_reg;   // pulse b active
  logic             clk_out_reg;  // backplane bit clock
  logic             txen_act_reg; // driver enable active

  // buffer drain side
  wire        buf_valid;   // bit waiting
  wire [0:0]  buf_data;    // waiting bit
  wire        buf_pop;     // take bit
  // decodes
  wire        cell_end;    // last phase of a cell
  wire        rate_ok;     // mode allowed at this rate
  wire        sending;     // sequencer in send
  wire        send_one;    // current cell carries a one
  wire        pa_next;     // pulse a next level
  wire        pb_next;     // pulse b next level
  wire        open_drain;  // pin a released when idle
  wire        pol_high;    // enable active high

  // transmit buffer: back-pressure reaches the bit source
  lpc_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_tx_fifo (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (i_tx_valid),
    .i_in_data   (i_tx_bit),
    .o_in_ready  (o_tx_ready),
    .o_out_valid (buf_valid),
    .o_out_data  (buf_data),
    .i_out_ready (buf_pop)
  );

  // receive path: sense follows the captured mode
  lpc_rx_recover u_rx (
    .i_clk             (i_clk),
    .i_resetn          (i_resetn),
    .i_line_receive_in (i_line_receive_in),
    .i_backplane       (bp_reg),
    .o_rx_valid        (o_rx_valid),
    .o_rx_bit          (o_rx_bit),
    .o_rx_active       (o_rx_active)
  );

  // basic decodes
  assign cell_end = (cnt_reg == CELL_LAST);
  assign rate_ok  = bp_reg || i_rate_is_2p5;
  assign sending  = (state_reg == LPC_TX_SEND);
  assign send_one = sending && bit_reg;
  assign o_rate_fault = !rate_ok;
  assign o_tx_busy    = txen_act_reg;

  // a bit is taken at each cell boundary while the stream lasts
  assign buf_pop = cell_end && buf_valid && (sending || rate_ok);

  // pulse shapes: hybrid splits the one into a then b
  assign pa_next = send_one &&
                   (bp_reg ? (cnt_reg < BP_END)
                           : (cnt_reg < HYB_A_END));
  assign pb_next = send_one && !bp_reg &&
                   (cnt_reg >= HYB_A_END) && (cnt_reg < HYB_B_END);

  // driver style and enable polarity
  assign open_drain = bp_reg && !pp_reg;
  assign pol_high   = bp_reg && strap_gnd_reg;

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LPC_TX_IDLE: begin
        // start only on a cell boundary, and only where allowed
        if (cell_end && buf_valid && rate_ok) state_next = LPC_TX_SEND;
      end
      LPC_TX_SEND: begin
        // stop once the buffer runs dry at a boundary
        if (cell_end && !buf_valid) state_next = LPC_TX_IDLE;
      end
      default: state_next = LPC_TX_IDLE;
    endcase
  end

  // sequencer, phase and current bit
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_reg <= LPC_TX_IDLE;
      cnt_reg   <= PH_ZERO;
      bit_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cell_end ? PH_ZERO : cnt_reg + PH_ONE;
      if (buf_pop) bit_reg <= buf_data[0];
    end
  end

  // mode bits follow their inputs only while idle; frozen on the start edge
  // so the rate test that allowed the start and the captured mode agree
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      bp_reg <= 1'b0;
      pp_reg <= 1'b0;
    end else if (state_next == LPC_TX_IDLE) begin
      bp_reg <= i_backplane_mode;
      pp_reg <= i_pulse_driver_push_pull_select;
    end
  end

  // strap capture: sampled through reset, held afterwards
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      strap_gnd_reg <= !i_line_pulse_b_n;
      run_reg       <= 1'b0;
    end else begin
      run_reg <= 1'b1;
    end
  end

  // registered pin activity, quiet in reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pa_act_reg   <= 1'b0;
      pb_act_reg   <= 1'b0;
      clk_out_reg  <= 1'b1;
      txen_act_reg <= 1'b0;
    end else begin
      pa_act_reg   <= pa_next;
      pb_act_reg   <= pb_next;
      clk_out_reg  <= (cnt_reg < CELL_HALF);
      txen_act_reg <= sending;
    end
  end

  // pin a: open-drain only pulls low, push-pull drives both levels
  assign o_line_pulse_a_n  = !pa_act_reg;
  assign o_line_pulse_a_oe = run_reg && (open_drain ? pa_act_reg : 1'b1);

  // pin b: dipulse half in hybrid, bit clock on backplane;
  // released in reset and, on the backplane, when strapped low so the strap holds
  assign o_line_pulse_b_n  = bp_reg ? clk_out_reg : !pb_act_reg;
  assign o_line_pulse_b_oe = run_reg && !pol_high;

  // driver enable with strapped polarity
  assign o_transmit_drive_enable_n = pol_high ? txen_act_reg : !txen_act_reg;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_a_low2;
    !o_line_pulse_a_n [*2] ##1 o_line_pulse_a_n;
  endsequence
  sequence s_b_low2;
    !o_line_pulse_b_n [*2] ##1 o_line_pulse_b_n;
  endsequence
  sequence s_a_low4;
    pa_act_reg [*4] ##1 !pa_act_reg;
  endsequence

  a_hyb_dipulse_a: assert property (
    ($fell(o_line_pulse_a_n) && !bp_reg) |-> s_a_low2)
    else $error("hybrid pulse a not two cycles");

  a_hyb_dipulse_b: assert property (
    ($rose(o_line_pulse_a_n) && !bp_reg && $past(!bp_reg)) |-> s_b_low2)
    else $error("hybrid pulse b does not follow a");

  a_hyb_no_overlap: assert property (
    !bp_reg |-> !(pa_act_reg && pb_act_reg))
    else $error("hybrid pulses overlap");

  a_hyb_zero_idle: assert property (
    (sending && !bit_reg && !bp_reg) |=> (!pa_act_reg && !pb_act_reg))
    else $error("pulse during a zero cell");

  a_rate_block: assert property (
    (!sending && !rate_ok) |=> !sending)
    else $error("hybrid send started at wrong rate");

  a_bp_pulse_len: assert property (
    ($rose(pa_act_reg) && bp_reg) |-> s_a_low4)
    else $error("backplane pulse not four cycles");

  a_od_release: assert property (
    (open_drain && !pa_act_reg) |-> !o_line_pulse_a_oe)
    else $error("open-drain pin driven while idle");

  // a mode change mid-period ends the check rather than failing it
  a_bp_clock_run: assert property (disable iff (!i_resetn || !bp_reg)
    ($rose(o_line_pulse_b_n) && $past(bp_reg)) |->
      o_line_pulse_b_n [*4] ##1 !o_line_pulse_b_n)
    else $error("backplane clock half period wrong");

  // while a pulse is out the enable sits at its active level for the strap
  a_pulse_gated: assert property (
    pa_act_reg |-> (o_transmit_drive_enable_n == pol_high))
    else $error("pulse without driver enable");

  a_hyb_polarity: assert property (
    !bp_reg |-> (o_transmit_drive_enable_n == !txen_act_reg))
    else $error("strap altered enable in hybrid mode");

  // pin b carries no dipulse half on the backplane
  a_bp_b_quiet: assert property (
    bp_reg |-> !pb_act_reg)
    else $error("pulse b active in backplane mode");

  // a hybrid stream only starts with the rate at 2.5 Mbps
  a_hyb_rate_start: assert property (
    ($rose(sending) && !bp_reg) |-> $past(i_rate_is_2p5))
    else $error("hybrid stream started at wrong rate");

  // push-pull and hybrid drive pin a at all times out of reset
  a_pa_drive_on: assert property (
    (run_reg && !open_drain) |-> o_line_pulse_a_oe)
    else $error("pin a released while push-pull");

  // the strap keeps its reset sample for the whole run
  a_strap_held: assert property (
    $past(i_resetn) |-> $stable(strap_gnd_reg))
    else $error("strap sample changed outside reset");

  // sequencer and pin activity are cleared by reset
  a_reset_seq_idle: assert property (@(posedge i_clk) disable iff (1'b0)
    !$past(i_resetn) |-> (!sending && !pa_act_reg && !pb_act_reg && !o_tx_busy))
    else $error("transmitter active in reset");

  // reset leaves hybrid mode and the open-drain driver selected
  a_reset_defaults: assert property (@(posedge i_clk) disable iff (1'b0)
    !$past(i_resetn) |-> (!bp_reg && !pp_reg))
    else $error("mode bits not cleared by reset");

  a_reset_quiet: assert property (@(posedge i_clk) disable iff (1'b0)
    !$past(i_resetn) |-> (!o_line_pulse_a_oe && !o_line_pulse_b_oe &&
                          o_transmit_drive_enable_n))
    else $error("outputs active in reset");
endmodule : lpc_codec
`default_nettype wire

// file: rtl/lpc_pkg.sv
// Purpose: shared constants of the line pulse codec
// Assumes: 20 MHz core clock, 2.5 Mbps bit cells
// Notes:   times are kept in ns, cycle counts derive from them
package lpc_pkg;
  // core clock period
  localparam int CLK_NS      = 50;
  // nominal bit cell at 2.5 Mbps
  localparam int CELL_NS     = 400;
  // each half of the hybrid dipulse
  localparam int HYB_PULSE_NS = 100;
  // single pulse in backplane mode
  localparam int BP_PULSE_NS = 200;
  // receive position tolerance either way
  localparam int RX_TOL_NS   = 100;

  // cycle counts (nominal widths round down, never below one)
  localparam int CELL_CYC    = CELL_NS / CLK_NS;
  localparam int HYB_CYC_I   = (HYB_PULSE_NS / CLK_NS < 1) ? 1 : HYB_PULSE_NS / CLK_NS;
  localparam int BP_CYC_I    = (BP_PULSE_NS / CLK_NS < 1) ? 1 : BP_PULSE_NS / CLK_NS;
  localparam int RX_TOL_CYC  = RX_TOL_NS / CLK_NS;

  // phase counter width and typed phase marks
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CELL_LAST  = CNT_W'(CELL_CYC - 1);
  localparam logic [CNT_W-1:0] CELL_HALF  = CNT_W'(CELL_CYC / 2);
  localparam logic [CNT_W-1:0] HYB_A_END  = CNT_W'(HYB_CYC_I);
  localparam logic [CNT_W-1:0] HYB_B_END  = CNT_W'(2 * HYB_CYC_I);
  localparam logic [CNT_W-1:0] BP_END     = CNT_W'(BP_CYC_I);
  localparam logic [CNT_W-1:0] PH_ZERO    = 3'h0;
  localparam logic [CNT_W-1:0] PH_ONE     = 3'h1;
  // receive decision phase, past the late tolerance
  localparam logic [CNT_W-1:0] RX_DECIDE  = CNT_W'(RX_TOL_CYC + 2);

  // empty cells counted before the next empty one ends receive activity
  localparam logic [2:0] RX_IDLE_LAST = 3'h5;

  // transmit buffer shape
  localparam int FIFO_W = 1;
  localparam int FIFO_D = 16;

  // transmit sequencer states
  typedef enum logic [0:0] {
    LPC_TX_IDLE = 1'b0,
    LPC_TX_SEND = 1'b1
  } lpc_tx_state_t;
endpackage : lpc_pkg

// file: rtl/lpc_fifo.sv
// Purpose: flop based FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active low reset
// Notes:   handshake outputs are combinational from pointers
`timescale 1ns/1ps
`default_nettype none
module lpc_fifo #(
  parameter int W = 1,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_reg [D];   // storage
  logic [AW:0]  wr_ptr_reg;    // write pointer with wrap bit
  logic [AW:0]  rd_ptr_reg;    // read pointer with wrap bit
  wire          full;          // no free slot
  wire          empty;         // nothing stored
  wire          push;          // word accepted
  wire          pop;           // word delivered

  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                 (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign push  = i_in_valid && !full;
  assign pop   = i_out_ready && !empty;
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  // pointer update
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  // storage write, no reset needed
  always_ff @(posedge i_clk) begin
    if (push) mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
  end
endmodule : lpc_fifo
`default_nettype wire

// file: rtl/lpc_rx_recover.sv
// Purpose: recovers NRZ bits from receive line pulses
// Assumes: line input synchronous to the clock
// Notes:   phase realigns on each leading pulse edge
`timescale 1ns/1ps
`default_nettype none
module lpc_rx_recover
  import lpc_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // line and mode
  input  wire logic i_line_receive_in,
  input  wire logic i_backplane,
  // recovered stream
  output logic      o_rx_valid,
  output logic      o_rx_bit,
  output logic      o_rx_active
);
  logic             rx_reg;      // pulse level, one = active
  logic             prev_reg;    // previous pulse level
  logic [CNT_W-1:0] ph_reg;      // phase within cell
  logic             seen_reg;    // pulse seen this cell
  logic             act_reg;     // stream in progress
  logic [2:0]       zero_reg;    // run of empty cells
  logic             valid_reg;   // bit strobe
  logic             bit_reg;     // bit value
  wire              edge_on;     // leading edge of a pulse
  wire              decide;      // cell decision point
  wire              quiet_end;   // too many empty cells

  assign edge_on   = rx_reg && !prev_reg;
  assign decide    = (ph_reg == RX_DECIDE) && !edge_on;
  assign quiet_end = !seen_reg && (zero_reg == RX_IDLE_LAST);
  assign o_rx_valid  = valid_reg;
  assign o_rx_bit    = bit_reg;
  assign o_rx_active = act_reg;

  // normalise pulse sense: positive in hybrid, negative on backplane
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rx_reg   <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      rx_reg   <= i_backplane ? !i_line_receive_in : i_line_receive_in;
      prev_reg <= rx_reg;
    end
  end

  // phase tracks pulses so ±tolerance still lands in its cell
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ph_reg   <= PH_ZERO;
      seen_reg <= 1'b0;
    end else begin
      ph_reg   <= edge_on ? PH_ZERO : ph_reg + PH_ONE;
      seen_reg <= edge_on || (seen_reg && !decide);
    end
  end

  // decision: pulse gives one, empty cell gives zero
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      act_reg   <= 1'b0;
      zero_reg  <= 3'h0;
      valid_reg <= 1'b0;
      bit_reg   <= 1'b0;
    end else begin
      valid_reg <= decide && act_reg;
      if (decide) bit_reg <= seen_reg;
      if (edge_on) act_reg <= 1'b1;
      else if (decide && quiet_end) act_reg <= 1'b0;
      if (decide) zero_reg <= seen_reg ? 3'h0 : zero_reg + 3'h1;
    end
  end

  // a lone pulse yields a one within the decision window
  a_rx_one_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
    edge_on ##1 !edge_on [*5] |-> ##[0:1] (o_rx_valid && o_rx_bit))
    else $error("received pulse not turned into a one");
endmodule : lpc_rx_recover
`default_nettype wire

// file: sim/lpc_line_model.sv
// Purpose: far side of the codec: receive line and pin b strap
// Assumes: trains are played one step after the rising clock edge
// Notes:   receive pulses are two cycles wide, displaced up to two cycles
`timescale 1ns/1ps
`default_nettype none
module lpc_line_model (
  // clock
  input  wire logic i_clk,
  // far side configuration
  input  wire logic i_backplane,
  input  wire logic i_strap_ground,
  // pin b as driven by the codec
  input  wire logic i_pin_b_n,
  input  wire logic i_pin_b_oe,
  // resolved lines
  output logic      o_pin_b_level,
  output logic      o_receive_in
);
  logic   playing = 1'b0;         // a pulse train is on the line
  logic   rx_r    = 1'b0;         // line level during a train
  integer seed    = 32'h8db06f68; // source of the displacement

  // a strap stays grounded for good, a released pin is pulled up
  assign o_pin_b_level = i_strap_ground ? 1'b0 : (i_pin_b_oe ? i_pin_b_n : 1'b1);
  // idle level: low behind the coupler, pulled up on the backplane
  assign o_receive_in  = playing ? rx_r : i_backplane;

  // one pulse per one bit, idle cells for zeros
  task automatic play(input logic [31:0] bits, input int n);
    logic lv[$];
    int   st;
    int   nom;
    // room for the drift that the displacements may add up to
    for (int i = 0; i < n * 8 + 32; i++) lv.push_back(i_backplane);
    // displacement is taken against the cell grid the last pulse set
    nom = 4;
    for (int i = 0; i < n; i++) begin
      if (bits[i]) begin
        st = nom + ($unsigned($random(seed)) % 5) - 2;
        lv[st]     = ~i_backplane;
        lv[st + 1] = ~i_backplane;
        nom        = st;
      end
      nom = nom + 8;
    end
    rx_r    = i_backplane;
    playing = 1'b1;
    foreach (lv[i]) begin
      @(posedge i_clk);
      #1;
      rx_r = lv[i];
    end
    playing = 1'b0;
  endtask : play
endmodule : lpc_line_model
`default_nettype wire

// file: sim/lpc_codec_test.sv
// Purpose: self-checking bench of the line pulse codec
// Assumes: 20 MHz clock, line model on the far side
// Notes:   random bits from a fixed seed, first bit forced to one
`timescale 1ns/1ps
`default_nettype none
module lpc_codec_test;
  logic   clk = 1'b0;       // bench clock
  logic   resetn = 1'b0;    // synchronous reset
  logic   bp_mode = 1'b0;   // mode bit, clear is hybrid
  logic   pp_sel = 1'b0;    // pin a driver style
  logic   rate_ok = 1'b0;   // node rate level
  logic   strap_gnd = 1'b0; // pin b strapped to ground
  logic   tx_valid = 1'b0;  // bit offered
  logic   tx_bit = 1'b0;    // bit value
  logic   tx_ready, rx_valid, rx_bit, rx_active, rate_fault, tx_busy;
  logic   pa_n, pa_oe, pb_n, pb_oe, pb_lvl, rx_in, ten_n;
  integer seed = 32'h8db06f68;            // stimulus seed
  int     num_errors = 0;                 // mismatches
  int     comparisons = 0;                // compares made
  int     cyc = 0;                        // cycle count
  int     a_run = 0;                      // current low run on pin a
  int     b_run = 0;                      // current low run on pin b
  int     a_st[$], a_w[$], b_st[$], b_w[$]; // pulse starts and widths
  logic   rx_q[$];                        // recovered bits
  logic   txq[$];                         // bits taken by the buffer

  lpc_codec u_dut (
    .i_clk(clk), .i_resetn(resetn), .i_backplane_mode(bp_mode),
    .i_pulse_driver_push_pull_select(pp_sel), .i_rate_is_2p5(rate_ok),
    .i_tx_valid(tx_valid), .i_tx_bit(tx_bit), .o_tx_ready(tx_ready),
    .o_rx_valid(rx_valid), .o_rx_bit(rx_bit), .o_rx_active(rx_active),
    .o_rate_fault(rate_fault), .o_tx_busy(tx_busy),
    .o_line_pulse_a_n(pa_n), .o_line_pulse_a_oe(pa_oe),
    .i_line_pulse_b_n(pb_lvl), .o_line_pulse_b_n(pb_n), .o_line_pulse_b_oe(pb_oe),
    .i_line_receive_in(rx_in), .o_transmit_drive_enable_n(ten_n)
  );

  lpc_line_model u_line (
    .i_clk(clk), .i_backplane(bp_mode), .i_strap_ground(strap_gnd),
    .i_pin_b_n(pb_n), .i_pin_b_oe(pb_oe), .o_pin_b_level(pb_lvl), .o_receive_in(rx_in)
  );

  // 50 ns clock
  initial begin
    forever #25 clk = ~clk;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // counts, verdict and end of run
  task automatic conclude();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // step past the edge by a fixed small delay
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // pulse watcher: starts, widths, enable level, recovered bits
  always @(posedge clk) begin
    cyc++;
    if (pa_oe === 1'b1 && pa_n === 1'b0) begin
      if (a_run == 0) a_st.push_back(cyc);
      a_run++;
      check(ten_n, bp_mode & strap_gnd);
      check(tx_busy, 1'b1);
    end else if (a_run > 0) begin
      a_w.push_back(a_run);
      a_run = 0;
    end
    if (!bp_mode && pb_oe === 1'b1 && pb_n === 1'b0) begin
      if (b_run == 0) b_st.push_back(cyc);
      b_run++;
    end else if (b_run > 0) begin
      b_w.push_back(b_run);
      b_run = 0;
    end
    if (rx_valid === 1'b1) rx_q.push_back(rx_bit);
  end

  // reset with a given strap, checking the quiet pins
  task automatic do_reset(input logic s);
    resetn    = 1'b0;
    strap_gnd = s;
    tick(1);
    check(pa_oe, 1'b0);
    check(pa_n, 1'b1);
    check(pb_oe, 1'b0);
    check(pb_n, 1'b1);
    check(tx_busy, 1'b0);
    if (!s) check(ten_n, 1'b1);
    tick(5);
    resetn = 1'b1;
    tick(2);
  endtask : do_reset

  // offer n random bits back to back, stop when the buffer stays full
  task automatic push_bits(input int n, output int taken);
    int w;
    taken = 0;
    txq.delete();
    a_st.delete(); a_w.delete(); b_st.delete(); b_w.delete();
    tx_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      tx_bit = (i == 0) ? 1'b1 : 1'($random(seed));
      w = 0;
      while (tx_ready !== 1'b1 && w < 20) begin
        tick();
        w++;
      end
      if (tx_ready !== 1'b1) break;
      txq.push_back(tx_bit);
      tick();
      taken++;
    end
    tx_valid = 1'b0;
  endtask : push_bits

  // expected pulses from the bits taken
  task automatic check_tx();
    int pos[$];
    int w;
    w = bp_mode ? lpc_pkg::BP_CYC_I : lpc_pkg::HYB_CYC_I;
    foreach (txq[i]) if (txq[i]) pos.push_back(i);
    check(a_st.size(), pos.size());
    foreach (pos[k]) begin
      check(a_w[k], w);
      check(a_st[k] - a_st[0], lpc_pkg::CELL_CYC * (pos[k] - pos[0]));
      if (!bp_mode) begin
        check(b_st[k], a_st[k] + w);
        check(b_w[k], w);
      end
    end
  endtask : check_tx

  // play twelve bits into the receiver and compare the stream
  task automatic rx_run(input logic b);
    logic [31:0] bits;
    int          w;
    bp_mode = b;
    bits    = $random(seed);
    bits[0] = 1'b1;
    // a mid-train one keeps every zero run inside the activity window
    bits[6] = 1'b1;
    tick(70);
    check(rx_active, 1'b0);
    rx_q.delete();
    u_line.play(bits, 12);
    w = 0;
    while (rx_q.size() < 12 && w < 200) begin
      tick();
      w++;
    end
    for (int i = 0; i < 12; i++) check(rx_q[i], bits[i]);
  endtask : rx_run

  // watchdog
  initial begin
    #(50 * 20000);
    num_errors++;
    conclude();
  end

  // main sequence
  initial begin
    int taken;
    do_reset(1'b0);
    // hybrid with the rate low: buffer fills, nothing leaves
    push_bits(20, taken);
    check(taken, lpc_pkg::FIFO_D);
    check(rate_fault, 1'b1);
    tick(40);
    check(a_st.size(), 0);
    rate_ok = 1'b1;
    tick(170);
    check(rate_fault, 1'b0);
    check_tx();
    // backplane: driver style, bit clock, single pulses
    bp_mode = 1'b1;
    tick(2);
    check(pa_oe, 1'b0);
    pp_sel = 1'b1;
    tick(2);
    check(pa_oe, 1'b1);
    taken = 0;
    while (pb_n !== 1'b0 && taken < 20) begin
      tick();
      taken++;
    end
    while (pb_n !== 1'b1 && taken < 40) begin
      tick();
      taken++;
    end
    for (int i = 0; i < 8; i++) begin
      check(pb_n, i < 4);
      tick();
    end
    push_bits(12, taken);
    tick(140);
    check_tx();
    rx_run(1'b0);
    rx_run(1'b1);
    // grounded strap: active high enable in backplane only
    do_reset(1'b1);
    check(pb_oe, 1'b0);
    push_bits(8, taken);
    tick(110);
    check_tx();
    check(ten_n, 1'b0);
    bp_mode = 1'b0;
    do_reset(1'b1);
    push_bits(8, taken);
    tick(110);
    check_tx();
    check(ten_n, 1'b1);
    conclude();
  end
endmodule : lpc_codec_test
`default_nettype wire
